// [rtl/ats_pkg.sv]
// Summary of operation
// - Arithmetic traps set sticky cause flags until written
// - Trap destination sets one bit of hidden mask
// - Reads present mask bits F31..F0, then I31..I0
// - A read clears the mask bit it presented if no other read came in the three cycles before it
// - Any write clears bits 8..2, keeps mask
// - Clear and shift land three cycles after read
// - Mask window bit 33, read-to-clear
// - Bit 8 on integer or convert overflow
// - Separate float cause flags in bits 7..3
// - Bit 2 set if all float traps qualified
// - Unqualified float trap clears bit 2 until write
`default_nettype none
package ats_pkg;

	// ----------------------------------------
	// Register layout
	// ----------------------------------------
	localparam int unsigned ATS_DATA_W  = 64;
	localparam int unsigned ATS_MASK_W  = 64;
	localparam int unsigned ATS_WIN_BIT = 33;
	localparam int unsigned ATS_FLG_HI  = 8;
	localparam int unsigned ATS_FLG_LO  = 2;
	localparam int unsigned ATS_IOV     = 8;
	localparam int unsigned ATS_INE     = 7;
	localparam int unsigned ATS_UNF     = 6;
	localparam int unsigned ATS_FOV     = 5;
	localparam int unsigned ATS_DZE     = 4;
	localparam int unsigned ATS_INV     = 3;
	localparam int unsigned ATS_SWC     = 2;

	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic [6:0]  ATS_FLG_RST  = 7'h00;
	localparam logic [63:0] ATS_MASK_RST = 64'h0;
	localparam logic [5:0]  ATS_PTR_RST  = 6'h00;
	localparam logic [5:0]  ATS_PTR_TOP  = 6'h3f;
	localparam int unsigned ATS_CLR_LAT  = 3;

	// ----------------------------------------
	// Trap report from one execution unit
	// ----------------------------------------
	typedef struct packed {
		logic       vld;
		logic       is_fp;
		logic       sw_compl;
		logic       integer_overflow_flag;
		logic       imprecise_result_flag;
		logic       unf;
		logic       float_overflow_flag;
		logic       divide_zero_flag;
		logic       bad_operation_flag;
		logic       dest_fp;
		logic [4:0] dest_num;
	} ats_trap_t;

endpackage : ats_pkg
`default_nettype wire

// [rtl/ats_summary.sv]
`timescale 1ns/100ps
`default_nettype none
module ats_summary
(
	input  wire logic              clk_i,
	input  wire logic              sys_rst_i,
	input  wire logic              rd_i,
	input  wire logic              wr_i,
	input  wire ats_pkg::ats_trap_t int_trap_i,
	input  wire ats_pkg::ats_trap_t fp_trap_i,
	output logic [63:0]            rdata_o,
	output logic                   rd_ack_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [ats_pkg::ATS_FLG_HI:ats_pkg::ATS_FLG_LO] flags_q;
	logic [ats_pkg::ATS_FLG_HI:ats_pkg::ATS_FLG_LO] flags_d;
	logic                                          blk_q;
	logic                                          blk_d;
	logic [ats_pkg::ATS_MASK_W-1:0]                mask_q;
	logic [ats_pkg::ATS_MASK_W-1:0]                mask_d;
	logic [5:0]                                    ptr_q;
	logic [5:0]                                    ptr_d;
	logic [ats_pkg::ATS_CLR_LAT-1:0]               rdp_q;
	logic [ats_pkg::ATS_CLR_LAT-1:0]               rdp_d;
	logic [63:0]                                   rdata_q;
	logic [63:0]                                   rdata_d;
	logic                                          ack_q;
	logic [5:0]                                    win_idx;
	logic                                          any_trap;
	ats_pkg::ats_trap_t                            trp [2];

	assign trp[0]   = int_trap_i;
	assign trp[1]   = fp_trap_i;
	assign any_trap = int_trap_i.vld | fp_trap_i.vld;
	// Window walks from logical 63 (F31) down to 0 (I0)
	assign win_idx  = ats_pkg::ATS_PTR_TOP - ptr_q;

	// ----------------------------------------
	// Cause flags and completion tracking
	// ----------------------------------------
	always_comb
	begin
		flags_d = flags_q;
		blk_d   = blk_q;
		// Write clears first so a same-cycle trap still lands
		if (wr_i)
		begin
			flags_d = ats_pkg::ATS_FLG_RST;
			blk_d   = 1'b0;
		end
		for (int u = 0; u < 2; u++)
		begin
			if (trp[u].vld)
			begin
				flags_d[ats_pkg::ATS_IOV] = flags_d[ats_pkg::ATS_IOV] | trp[u].integer_overflow_flag;
				flags_d[ats_pkg::ATS_INE] = flags_d[ats_pkg::ATS_INE] | trp[u].imprecise_result_flag;
				flags_d[ats_pkg::ATS_UNF] = flags_d[ats_pkg::ATS_UNF] | trp[u].unf;
				flags_d[ats_pkg::ATS_FOV] = flags_d[ats_pkg::ATS_FOV] | trp[u].float_overflow_flag;
				flags_d[ats_pkg::ATS_DZE] = flags_d[ats_pkg::ATS_DZE] | trp[u].divide_zero_flag;
				flags_d[ats_pkg::ATS_INV] = flags_d[ats_pkg::ATS_INV] | trp[u].bad_operation_flag;
				if (trp[u].is_fp)
				begin
					if (!trp[u].sw_compl)
					begin
						flags_d[ats_pkg::ATS_SWC] = 1'b0;
						blk_d                     = 1'b1;
					end
					else if (!blk_d)
					begin
						flags_d[ats_pkg::ATS_SWC] = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			flags_q <= ats_pkg::ATS_FLG_RST;
			blk_q   <= 1'b0;
		end
		else
		begin
			flags_q <= flags_d;
			blk_q   <= blk_d;
		end
	end

	// ----------------------------------------
	// Hidden destination mask and window
	// ----------------------------------------
	always_comb
	begin
		mask_d = mask_q;
		ptr_d  = ptr_q;
		// Pending reads ride a shift pipe as deep as the clear latency
		rdp_d  = {rdp_q[ats_pkg::ATS_CLR_LAT-2:0], rd_i};
		// Late clear uses the live pointer; close reads see stale bits
		if (rdp_q[ats_pkg::ATS_CLR_LAT-1])
		begin
			mask_d[win_idx] = 1'b0;
			ptr_d           = ptr_q + 6'h01;
		end
		// Record after the clear so a new trap is never lost
		for (int u = 0; u < 2; u++)
		begin
			if (trp[u].vld)
			begin
				mask_d[{trp[u].dest_fp, trp[u].dest_num}] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			mask_q <= ats_pkg::ATS_MASK_RST;
			ptr_q  <= ats_pkg::ATS_PTR_RST;
			rdp_q  <= '0;
		end
		else
		begin
			mask_q <= mask_d;
			ptr_q  <= ptr_d;
			rdp_q  <= rdp_d;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb
	begin
		rdata_d = rdata_q;
		// Flags as they stood before any trap landing this cycle
		if (rd_i)
		begin
			rdata_d                                           = '0;
			rdata_d[ats_pkg::ATS_WIN_BIT]                     = mask_q[win_idx];
			rdata_d[ats_pkg::ATS_FLG_HI:ats_pkg::ATS_FLG_LO] = flags_q;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			rdata_q <= '0;
			ack_q   <= 1'b0;
		end
		else
		begin
			rdata_q <= rdata_d;
			ack_q   <= rd_i;
		end
	end

	assign rdata_o  = rdata_q;
	assign rd_ack_o = ack_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	// Nothing is judged while reset holds
	default disable iff (sys_rst_i);

	chk_flag_sticky: assert property (
		!wr_i |=> ((flags_q[8:3] & $past(flags_q[8:3])) == $past(flags_q[8:3])))
		else $error("cause flag dropped without write");

	chk_iov_set: assert property (
		int_trap_i.vld && int_trap_i.integer_overflow_flag |=> flags_q[ats_pkg::ATS_IOV])
		else $error("integer overflow not flagged");

	chk_fp_cause: assert property (
		fp_trap_i.vld && fp_trap_i.imprecise_result_flag && fp_trap_i.divide_zero_flag |=> flags_q[7] && flags_q[4])
		else $error("float cause flags not set");

	chk_write_clear: assert property (
		wr_i && !any_trap |=> flags_q == '0)
		else $error("write did not clear flags");

	chk_write_mask: assert property (
		wr_i && !any_trap && !rdp_q[2] |=> mask_q == $past(mask_q))
		else $error("write disturbed mask");

	chk_dest_record: assert property (
		fp_trap_i.vld |=> mask_q[$past({fp_trap_i.dest_fp, fp_trap_i.dest_num})])
		else $error("destination not recorded");

	chk_shift_three: assert property (
		(rd_i && rdp_q == 3'h0) ##1 !rd_i [*2] |->
		##1 (ptr_q == $past(ptr_q, 3)) ##1 (ptr_q == $past(ptr_q, 4) + 6'h01))
		else $error("window shift not three cycles after read");

	chk_read_clear: assert property (
		(rd_i && rdp_q == 3'h0) ##1 !rd_i [*2] ##1 !any_trap |=> !mask_q[$past(win_idx, 4)])
		else $error("presented mask bit not cleared");

	chk_window_bit: assert property (
		rd_i |=> rd_ack_o && rdata_o[33] == $past(mask_q[win_idx]) && rdata_o[1:0] == 2'h0)
		else $error("window bit wrong");

	chk_swc_block: assert property (
		blk_q && !wr_i |=> !flags_q[ats_pkg::ATS_SWC])
		else $error("completion flag set while blocked");

	chk_swc_set: assert property (
		fp_trap_i.vld && fp_trap_i.is_fp && fp_trap_i.sw_compl && !blk_q && !int_trap_i.vld
		|=> flags_q[ats_pkg::ATS_SWC])
		else $error("completion flag not set");

	// ----------------------------------------
	// Checks on read data
	// ----------------------------------------
	chk_ack_pulse: assert property (
		!rd_i |=> !rd_ack_o)
		else $error("read acknowledge held too long");

	chk_rdata_hold: assert property (
		!rd_i |=> $stable(rdata_o))
		else $error("read data changed without a read");

	chk_rdata_flags: assert property (
		rd_i |=> rdata_o[ats_pkg::ATS_FLG_HI:ats_pkg::ATS_FLG_LO] == $past(flags_q))
		else $error("read data flags wrong");

	chk_rdata_spare: assert property (
		rd_i |=> rdata_o[63:34] == 30'h0 && rdata_o[32:9] == 24'h0)
		else $error("unused read data bits set");

	// ----------------------------------------
	// Checks on mask and window
	// ----------------------------------------
	chk_int_dest: assert property (
		int_trap_i.vld |=> mask_q[$past({int_trap_i.dest_fp, int_trap_i.dest_num})])
		else $error("integer destination not recorded");

	chk_trap_beats_clear: assert property (
		rdp_q[2] && fp_trap_i.vld && {fp_trap_i.dest_fp, fp_trap_i.dest_num} == win_idx
		|=> mask_q[$past(win_idx)])
		else $error("trap lost to read clear");

	chk_ptr_idle: assert property (
		!rdp_q[2] |=> $stable(ptr_q))
		else $error("window moved without a read");

	chk_ptr_wrap: assert property (
		rdp_q[2] && ptr_q == ats_pkg::ATS_PTR_TOP |=> ptr_q == ats_pkg::ATS_PTR_RST)
		else $error("window did not wrap");

	chk_mask_idle: assert property (
		!rdp_q[2] && !any_trap |=> $stable(mask_q))
		else $error("mask changed without trap or read");

	// ----------------------------------------
	// Checks on cause flags
	// ----------------------------------------
	chk_flags_idle: assert property (
		!wr_i && !any_trap |=> $stable(flags_q))
		else $error("flags changed without trap or write");

	chk_cvt_iov: assert property (
		fp_trap_i.vld && fp_trap_i.integer_overflow_flag |=> flags_q[ats_pkg::ATS_IOV])
		else $error("convert overflow not flagged");

	chk_fp_rest: assert property (
		fp_trap_i.vld && fp_trap_i.unf && fp_trap_i.float_overflow_flag && fp_trap_i.bad_operation_flag
		|=> flags_q[ats_pkg::ATS_UNF] && flags_q[ats_pkg::ATS_FOV] && flags_q[ats_pkg::ATS_INV])
		else $error("underflow, overflow or invalid not flagged");

	chk_swc_clear: assert property (
		fp_trap_i.vld && fp_trap_i.is_fp && !fp_trap_i.sw_compl
		|=> !flags_q[ats_pkg::ATS_SWC] && blk_q)
		else $error("unqualified trap kept completion flag");

	chk_blk_sticky: assert property (
		blk_q && !wr_i |=> blk_q)
		else $error("completion block released without write");

	chk_write_block: assert property (
		wr_i && !(fp_trap_i.vld && fp_trap_i.is_fp) && !(int_trap_i.vld && int_trap_i.is_fp)
		|=> !blk_q)
		else $error("write did not release completion block");

	chk_int_swc: assert property (
		int_trap_i.vld && !int_trap_i.is_fp && !fp_trap_i.vld && !wr_i
		|=> $stable(flags_q[ats_pkg::ATS_SWC]))
		else $error("integer trap touched completion flag");

	chk_swc_rise: assert property (
		!flags_q[ats_pkg::ATS_SWC] && !(fp_trap_i.vld && fp_trap_i.is_fp)
		&& !(int_trap_i.vld && int_trap_i.is_fp) |=> !flags_q[ats_pkg::ATS_SWC])
		else $error("completion flag rose without float trap");

	// ----------------------------------------
	// Coverage
	// ----------------------------------------
	cov_full_drain: cover property (ptr_q == ats_pkg::ATS_PTR_TOP ##1 rdp_q[2]);
	cov_swc_lost: cover property (flags_q[2] ##[1:20] (blk_q && !flags_q[2]));
	cov_read_one: cover property (rd_i ##1 rdata_o[33]);
	cov_set_clear: cover property (wr_i && any_trap);
	cov_both_units: cover property (int_trap_i.vld && fp_trap_i.vld);

endmodule : ats_summary
`default_nettype wire

// [test/ats_unit_model.sv]
`timescale 1ns/100ps
`default_nettype none
module ats_unit_model
(
	input  wire logic         clk_i,
	output var ats_pkg::ats_trap_t trap_o
);
	// ----------------------------------------
	// Execution unit trap reporter
	// ----------------------------------------
	initial trap_o = '0;
	// One-cycle report, then idle so nothing repeats
	task automatic send(input ats_pkg::ats_trap_t t);
		@(negedge clk_i);
		trap_o = t;
		@(negedge clk_i);
		trap_o = '0;
	endtask : send
endmodule : ats_unit_model
`default_nettype wire

// [test/ats_summary_test.sv]
`timescale 1ns/100ps
`default_nettype none
module ats_summary_test;
	logic               clk_i = 1'b0;
	logic               sys_rst_i = 1'b1;
	logic               rd_i = 1'b0;
	logic               wr_i = 1'b0;
	ats_pkg::ats_trap_t int_trap;
	ats_pkg::ats_trap_t fp_trap;
	logic [63:0]        rdata;
	logic               rd_ack;
	logic [8:2]         ef = 7'h00;
	logic [63:0]        em = 64'h0;
	logic [5:0]         ptr = 6'h00;
	logic               blk = 1'b0;
	logic [5:0]         hit = 6'h00;
	int                 bad_count = 0;
	int                 n_checks = 0;
	int                 cyc = 0;

	initial forever #20 clk_i = ~clk_i;

	ats_unit_model i_int (.clk_i(clk_i), .trap_o(int_trap));
	ats_unit_model i_fp (.clk_i(clk_i), .trap_o(fp_trap));
	ats_summary i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .rd_i(rd_i), .wr_i(wr_i),
		.int_trap_i(int_trap), .fp_trap_i(fp_trap), .rdata_o(rdata), .rd_ack_o(rd_ack));

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
		n_checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// Reads four edges apart so the clear and shift have landed
	task automatic rd();
		logic [63:0] e;
		@(negedge clk_i);
		rd_i = 1'b1;
		@(negedge clk_i);
		rd_i = 1'b0;
		e = 64'h0;
		e[33] = em[~ptr];
		e[8:2] = ef;
		chk("rd_ack", {63'h0, rd_ack}, 64'h1);
		chk("rdata", rdata, e);
		em[~ptr] = 1'b0;
		ptr = ptr + 6'h01;
		@(negedge clk_i);
		chk("rd_ack_drop", {63'h0, rd_ack}, 64'h0);
		chk("rdata_hold", rdata, e);
		@(negedge clk_i);
	endtask : rd

	task automatic wr();
		@(negedge clk_i);
		wr_i = 1'b1;
		// Model cleared before the edge so a same-cycle trap lands after
		ef = 7'h00;
		blk = 1'b0;
		@(negedge clk_i);
		wr_i = 1'b0;
	endtask : wr

	// Causes c are {iov, ine, unf, fov, dze, inv}
	task automatic trap(input logic fp, input logic sw, input logic [5:0] c, input logic [5:0] d);
		ats_pkg::ats_trap_t t;
		t = {1'b1, fp, sw, c, d};
		if (fp)
			i_fp.send(t);
		else
			i_int.send(t);
		ef[8:3] = ef[8:3] | c;
		em[d] = 1'b1;
		if (fp && !sw)
		begin
			ef[2] = 1'b0;
			blk = 1'b1;
		end
		else if (fp && !blk)
			ef[2] = 1'b1;
	endtask : trap

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			final_report();
		end
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		repeat (12) @(negedge clk_i);
		sys_rst_i = 1'b0;
		rd();
		for (int i = 0; i < 5; i++)
		begin
			trap(1'b1, 1'b1, 6'h01 << i, 6'h20 + 6'(i * 7));
			rd();
		end
		trap(1'b0, 1'b0, 6'h20, 6'h09);
		trap(1'b1, 1'b1, 6'h20, 6'h3e);
		rd();
		trap(1'b1, 1'b0, 6'h01, 6'h23);
		trap(1'b1, 1'b1, 6'h02, 6'h24);
		rd();
		trap(1'b0, 1'b0, 6'h00, ~ptr);
		wr();
		rd();
		trap(1'b1, 1'b1, 6'h04, 6'h11);
		repeat (128) rd();
		wr();
		trap(1'b1, 1'b1, 6'h08, ~ptr);
		repeat (32) rd();
		fork
			trap(1'b0, 1'b0, 6'h20, 6'h05);
			trap(1'b1, 1'b1, 6'h1f, 6'h3a);
		join
		rd();
		fork
			wr();
			trap(1'b1, 1'b0, 6'h10, 6'h30);
		join
		rd();
		hit = ~ptr;
		fork
			rd();
			begin
				repeat (3) @(negedge clk_i);
				trap(1'b1, 1'b1, 6'h01, hit);
			end
		join
		@(negedge clk_i);
		sys_rst_i = 1'b1;
		@(negedge clk_i);
		chk("rst_rdata", rdata, 64'h0);
		chk("rst_ack", {63'h0, rd_ack}, 64'h0);
		sys_rst_i = 1'b0;
		ef = 7'h00;
		em = 64'h0;
		ptr = 6'h00;
		blk = 1'b0;
		trap(1'b1, 1'b1, 6'h08, 6'h2a);
		repeat (33) rd();
		final_report();
	end
endmodule : ats_summary_test
`default_nettype wire
